// *** spb_pkg.sv ***
// Constants and types for the sequential program-counter break unit.
// Assumes one 125 MHz clock and a fetch stream presented one fetch per cycle.
// Behaviour
// - Three address channels, first, second and third, each compare fetch addresses.
// - Third channel also holds an execution count needed before it triggers.
// - Comparison covers the whole code space, independent of any software break area.
// - Two-bit mode: 0 independent, 1 third count, 2 second-third, 3 first-second-third.
// - Independent mode: any channel hit breaks alone; the count is ignored.
// - Break halts the core before the matched instruction executes.
// - Third count mode breaks after the programmed number of third fetches only.
// - Second-third mode counts third fetches only after a second-channel hit.
// - First-second-third mode needs first then second hit before counting third.
// - Counted modes never break before the third fetch count reaches the programmed value.
// - Each channel holds one address; a new write replaces the old one.
package spb_pkg;
  localparam int         ADDR_W = 24;
  localparam int         REG_AW = 8;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ADDR1    = 8'h04;
  localparam logic [7:0] OFS_ADDR2    = 8'h08;
  localparam logic [7:0] OFS_ADDR3    = 8'h0c;
  localparam logic [7:0] OFS_COUNT    = 8'h10;
  localparam logic [7:0] OFS_PROGRESS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h20;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EN_LSB   = 2;
  localparam int IRQ_BRK_BIT   = 0;
  localparam int IRQ_ARM_BIT   = 1;
  localparam int PROG_CNT_LSB  = 8;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int CLK_PERIOD_NS = 8;

  typedef enum logic [1:0] {
    MODE_INDEP = 2'h0,
    MODE_CNT3  = 2'h1,
    MODE_SEQ23 = 2'h2,
    MODE_SEQ13 = 2'h3
  } spb_mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'h1,
    SEQ_FIRST = 3'h2,
    SEQ_ARMED = 3'h4
  } spb_seq_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } spb_fetch_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [31:0]       wdata;
  } spb_bus_t;
endpackage : spb_pkg

// *** spb_break_unit.sv ***
// Sequential program-counter break unit with register port and interrupt.
// Assumes fetches arrive synchronous to i_mclk and the core stalls the
// fetched instruction in the same cycle that o_halt_req is high.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module spb_break_unit #(
  parameter int CNT_W = 16
) (
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire spb_pkg::spb_fetch_t i_fetch,
  input  wire logic                i_run_start,
  input  wire spb_pkg::spb_bus_t   i_bus,
  output logic [31:0]              o_rdata,
  output logic                     o_halt_req,
  output logic                     o_irq
);
  // Counter field of the progress register spans bits 31:8, so 24 bits at most
  if (CNT_W < 1 || CNT_W > 24) begin : g_bad_cnt_w
    $error("CNT_W must be 1..24");
  end

  logic [4:0]                  ctrl;
  logic [spb_pkg::ADDR_W-1:0]  addr1;
  logic [spb_pkg::ADDR_W-1:0]  addr2;
  logic [spb_pkg::ADDR_W-1:0]  addr3;
  logic [CNT_W-1:0]            count;
  logic [CNT_W-1:0]            fetch_cnt;
  logic [1:0]                  irq_stat;
  logic [1:0]                  irq_en;
  spb_pkg::spb_seq_t           seq;
  spb_pkg::spb_seq_t           next_seq;
  logic [CNT_W-1:0]            next_cnt;

  function automatic logic chan_hit(input logic en, input logic [spb_pkg::ADDR_W-1:0] want,
                                    input spb_pkg::spb_fetch_t f);
    chan_hit = en && f.valid && (f.addr == want);
  endfunction : chan_hit

  function automatic logic sel(input spb_pkg::spb_bus_t b, input logic [7:0] ofs);
    sel = (b.addr == ofs);
  endfunction : sel

  wire spb_pkg::spb_mode_t mode = spb_pkg::spb_mode_t'(ctrl[spb_pkg::CTRL_MODE_LSB +: 2]);
  wire [2:0] chan_en = ctrl[spb_pkg::CTRL_EN_LSB +: 3];

  // Full-width compare: no area bits participate
  wire hit1 = chan_hit(chan_en[0], addr1, i_fetch);
  wire hit2 = chan_hit(chan_en[1], addr2, i_fetch);
  wire hit3 = chan_hit(chan_en[2], addr3, i_fetch);

  wire counting  = (mode == spb_pkg::MODE_CNT3) || (seq == spb_pkg::SEQ_ARMED);
  wire count_hit = (mode != spb_pkg::MODE_INDEP) && counting && hit3;
  wire count_met = (fetch_cnt == count);
  wire brk_indep = (mode == spb_pkg::MODE_INDEP) && (hit1 || hit2 || hit3);
  wire brk_count = count_hit && count_met;
  wire brk       = brk_indep || brk_count;

  // Combinational so the core stalls the very fetch that matched
  assign o_halt_req = brk;

  wire wr_ctrl = i_bus.wr && sel(i_bus, spb_pkg::OFS_CTRL);
  wire restart = i_run_start || brk || wr_ctrl;

  always_comb begin
    next_seq = seq;
    case (seq)
      spb_pkg::SEQ_IDLE: begin
        if (mode == spb_pkg::MODE_SEQ23 && hit2) begin
          next_seq = spb_pkg::SEQ_ARMED;
        end else if (mode == spb_pkg::MODE_SEQ13 && hit1) begin
          next_seq = spb_pkg::SEQ_FIRST;
        end
      end
      spb_pkg::SEQ_FIRST: begin
        if (hit2) begin
          next_seq = spb_pkg::SEQ_ARMED;
        end
      end
      spb_pkg::SEQ_ARMED: next_seq = spb_pkg::SEQ_ARMED;
      default:            next_seq = spb_pkg::SEQ_IDLE;
    endcase
    if (restart) begin
      next_seq = spb_pkg::SEQ_IDLE;
    end
  end

  // Saturate rather than wrap so a large count never breaks early
  wire cnt_full = &fetch_cnt;
  always_comb begin
    next_cnt = fetch_cnt;
    if (restart) begin
      next_cnt = '0;
    end else if (count_hit && !cnt_full) begin
      next_cnt = fetch_cnt + 1'b1;
    end
  end

  wire armed_evt = (seq != spb_pkg::SEQ_ARMED) && (next_seq == spb_pkg::SEQ_ARMED);
  wire [1:0] irq_set = {armed_evt, brk};
  wire [1:0] irq_clr = (i_bus.wr && sel(i_bus, spb_pkg::OFS_IRQ_CLR)) ? i_bus.wdata[1:0] : 2'h0;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      seq       <= spb_pkg::SEQ_IDLE;
      fetch_cnt <= '0;
      irq_stat  <= 2'h0;
    end else begin
      seq       <= next_seq;
      fetch_cnt <= next_cnt;
      // Set wins over a clear in the same cycle
      irq_stat  <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl   <= spb_pkg::CTRL_RESET;
      addr1  <= '0;
      addr2  <= '0;
      addr3  <= '0;
      count  <= '0;
      irq_en <= 2'h0;
    end else if (i_bus.wr) begin
      if (wr_ctrl) ctrl <= i_bus.wdata[4:0];
      // A channel holds one address; rewriting replaces it
      if (sel(i_bus, spb_pkg::OFS_ADDR1)) addr1 <= i_bus.wdata[spb_pkg::ADDR_W-1:0];
      if (sel(i_bus, spb_pkg::OFS_ADDR2)) addr2 <= i_bus.wdata[spb_pkg::ADDR_W-1:0];
      if (sel(i_bus, spb_pkg::OFS_ADDR3)) addr3 <= i_bus.wdata[spb_pkg::ADDR_W-1:0];
      if (sel(i_bus, spb_pkg::OFS_COUNT)) count <= i_bus.wdata[CNT_W-1:0];
      if (sel(i_bus, spb_pkg::OFS_IRQ_EN)) irq_en <= i_bus.wdata[1:0];
    end
  end

  wire [31:0] progress = (32'(fetch_cnt) << spb_pkg::PROG_CNT_LSB) | 32'(seq);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (i_bus.addr)
      spb_pkg::OFS_CTRL:     rd_mux = {27'h0, ctrl};
      spb_pkg::OFS_ADDR1:    rd_mux = {8'h00, addr1};
      spb_pkg::OFS_ADDR2:    rd_mux = {8'h00, addr2};
      spb_pkg::OFS_ADDR3:    rd_mux = {8'h00, addr3};
      spb_pkg::OFS_COUNT:    rd_mux = {{(32-CNT_W){1'b0}}, count};
      spb_pkg::OFS_PROGRESS: rd_mux = progress;
      spb_pkg::OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat};
      spb_pkg::OFS_IRQ_EN:   rd_mux = {30'h0, irq_en};
      default:               rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_bus.rd ? rd_mux : 32'h0;
    end
  end

  assign o_irq = |(irq_stat & irq_en);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_indep_any_hit: assert property (
    (mode == spb_pkg::MODE_INDEP) && (hit1 || hit2 || hit3) |-> o_halt_req)
    else $error("independent hit did not halt");

  a_cnt3_ignore_12: assert property (
    (mode == spb_pkg::MODE_CNT3) && !hit3 |-> !o_halt_req)
    else $error("count mode halted without third hit");

  a_no_early_halt: assert property (
    (mode != spb_pkg::MODE_INDEP) && o_halt_req |-> hit3 && (fetch_cnt == count))
    else $error("counted halt before count reached");

  a_seq23_needs_second: assert property (
    (mode == spb_pkg::MODE_SEQ23) && (seq == spb_pkg::SEQ_IDLE) |-> !o_halt_req)
    else $error("second-third halted before second hit");

  a_seq13_order: assert property (
    (mode == spb_pkg::MODE_SEQ13) && (seq == spb_pkg::SEQ_IDLE) && hit2 && !hit1
      && !i_run_start && !wr_ctrl |=> seq == spb_pkg::SEQ_IDLE)
    else $error("second hit armed before first");

  a_clear_on_break: assert property (
    o_halt_req |=> (fetch_cnt == '0) && (seq == spb_pkg::SEQ_IDLE))
    else $error("progress not cleared by break");

  a_clear_on_start: assert property (
    i_run_start |=> (fetch_cnt == '0) && (seq == spb_pkg::SEQ_IDLE))
    else $error("progress not cleared by start");

  a_addr_replace: assert property (
    i_bus.wr && sel(i_bus, spb_pkg::OFS_ADDR3) |=> addr3 == $past(i_bus.wdata[spb_pkg::ADDR_W-1:0]))
    else $error("channel address not replaced");

  a_count_step: assert property (
    count_hit && !restart && !cnt_full |=> fetch_cnt == $past(fetch_cnt) + 1'b1)
    else $error("third fetch not counted");

  a_halt_same_cycle: assert property (
    (mode == spb_pkg::MODE_CNT3) && chan_en[2] && i_fetch.valid && (i_fetch.addr == addr3)
      && (fetch_cnt == count) |-> o_halt_req)
    else $error("halt not raised with the matching fetch");

  a_irq_level: assert property (
    |(irq_stat & irq_en) |-> o_irq)
    else $error("interrupt low with enabled status");

  a_halt_needs_fetch: assert property (
    o_halt_req |-> i_fetch.valid)
    else $error("halt raised without a fetch");

  a_indep_no_hit: assert property (
    (mode == spb_pkg::MODE_INDEP) && !(hit1 || hit2 || hit3) |-> !o_halt_req)
    else $error("independent mode halted without a hit");

  a_indep_no_count: assert property (
    (mode == spb_pkg::MODE_INDEP) |-> (fetch_cnt == '0) && (seq == spb_pkg::SEQ_IDLE))
    else $error("independent mode kept sequence progress");

  a_cnt3_no_seq: assert property (
    (mode == spb_pkg::MODE_CNT3) |-> (seq == spb_pkg::SEQ_IDLE))
    else $error("count mode advanced the sequence");

  // Sequencer: each step needs its own hit, and only a restart drops progress
  a_seq_onehot: assert property ($onehot(seq))
    else $error("sequence state not one-hot");

  a_seq23_ignore_first: assert property (
    (mode == spb_pkg::MODE_SEQ23) && (seq == spb_pkg::SEQ_IDLE) && hit1 && !hit2
      |=> seq == spb_pkg::SEQ_IDLE)
    else $error("first channel advanced second-third mode");

  a_seq23_arm: assert property (
    (mode == spb_pkg::MODE_SEQ23) && (seq == spb_pkg::SEQ_IDLE) && hit2 && !restart
      |=> seq == spb_pkg::SEQ_ARMED)
    else $error("second hit did not arm second-third mode");

  a_seq13_first: assert property (
    (mode == spb_pkg::MODE_SEQ13) && (seq == spb_pkg::SEQ_IDLE) && hit1 && !restart
      |=> seq == spb_pkg::SEQ_FIRST)
    else $error("first hit not recorded");

  a_first_wait_second: assert property (
    (mode == spb_pkg::MODE_SEQ13) && (seq == spb_pkg::SEQ_FIRST) && !hit2 && !restart
      |=> seq == spb_pkg::SEQ_FIRST)
    else $error("sequence left first step without second hit");

  a_armed_stays: assert property (
    (seq == spb_pkg::SEQ_ARMED) && !restart |=> seq == spb_pkg::SEQ_ARMED)
    else $error("armed sequence dropped without restart");

  a_ctrl_clears: assert property (
    wr_ctrl |=> (fetch_cnt == '0) && (seq == spb_pkg::SEQ_IDLE))
    else $error("mode write left progress behind");

  a_ctrl_write: assert property (
    wr_ctrl |=> ctrl == $past(i_bus.wdata[4:0]))
    else $error("mode register not written");

  a_cnt_hold: assert property (
    !count_hit && !restart |=> $stable(fetch_cnt))
    else $error("fetch counter moved without a counted hit");

  a_cnt_saturate: assert property (
    cnt_full && !restart |=> cnt_full)
    else $error("fetch counter wrapped");

  a_count_write: assert property (
    i_bus.wr && sel(i_bus, spb_pkg::OFS_COUNT) |=> count == $past(i_bus.wdata[CNT_W-1:0]))
    else $error("execution count not written");

  a_addr1_replace: assert property (
    i_bus.wr && sel(i_bus, spb_pkg::OFS_ADDR1) |=> addr1 == $past(i_bus.wdata[spb_pkg::ADDR_W-1:0]))
    else $error("first channel address not replaced");

  a_addr2_replace: assert property (
    i_bus.wr && sel(i_bus, spb_pkg::OFS_ADDR2) |=> addr2 == $past(i_bus.wdata[spb_pkg::ADDR_W-1:0]))
    else $error("second channel address not replaced");

  // Status bits are sticky until written with a one
  a_irq_break_set: assert property (
    o_halt_req |=> irq_stat[spb_pkg::IRQ_BRK_BIT])
    else $error("break did not set its status bit");

  a_irq_arm_set: assert property (
    armed_evt |=> irq_stat[spb_pkg::IRQ_ARM_BIT])
    else $error("arming did not set its status bit");

  a_irq_hold: assert property (
    irq_stat[spb_pkg::IRQ_BRK_BIT] && !irq_clr[spb_pkg::IRQ_BRK_BIT] |=> irq_stat[spb_pkg::IRQ_BRK_BIT])
    else $error("break status lost without a clear");

  a_irq_clear: assert property (
    irq_clr[spb_pkg::IRQ_BRK_BIT] && !irq_set[spb_pkg::IRQ_BRK_BIT] |=> !irq_stat[spb_pkg::IRQ_BRK_BIT])
    else $error("break status survived its clear");

  // Zero outside the reply cycle lets several slaves share an or-ed read bus
  a_rdata_idle: assert property (
    !i_bus.rd |=> o_rdata == 32'h0)
    else $error("read data outside the read reply cycle");

  c_indep_break: cover property ((mode == spb_pkg::MODE_INDEP) && o_halt_req);
  c_cnt3_break:  cover property ((mode == spb_pkg::MODE_CNT3) && o_halt_req && (count != '0));
  c_seq13_break: cover property ((mode == spb_pkg::MODE_SEQ13) && o_halt_req);
  c_set_clear:   cover property (irq_set[0] && irq_clr[0]);
  c_seq23_break: cover property ((mode == spb_pkg::MODE_SEQ23) && o_halt_req);
endmodule : spb_break_unit

// *** spb_fetch_src.sv ***
// Fetch stream model of the watched core, one fetch per cycle at most.
// Assumes the core holds the fetched instruction while o_halt_req is high.
`timescale 1ns/1ps
module spb_fetch_src (
  input  wire logic          i_mclk,
  input  wire logic          i_halt,
  output spb_pkg::spb_fetch_t o_fetch
);
  initial o_fetch = '0;
  // Valid stays up so fetches can run back to back
  task automatic fetch(input logic [23:0] a, output logic hit);
    @(posedge i_mclk);
    o_fetch <= {1'b1, a};
    @(negedge i_mclk);
    hit = i_halt;
  endtask : fetch
  // Idle address is scrambled so a stale value never matches by accident
  task automatic stop();
    @(posedge i_mclk);
    o_fetch <= {1'b0, ~o_fetch.addr};
  endtask : stop
endmodule : spb_fetch_src

// *** testbench.sv ***
// Self-checking bench for the break unit: random fetch streams per mode.
// Assumes the fetch model in spb_fetch_src and the register map of spb_pkg.
`timescale 1ns/1ps
module testbench;
  logic                i_mclk = 0, i_rst = 1, i_run_start = 0, halt, irq, hit;
  logic [31:0]         rdata;
  spb_pkg::spb_bus_t   bus = '0;
  spb_pkg::spb_fetch_t fetch;
  int                  n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [23:0]         a1, a2, a3, a;
  logic [1:0]          mode, r_seq;
  logic [23:0]         r_cnt, n;
  logic                brk, armd;
  spb_break_unit #(.CNT_W(16)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_fetch(fetch), .i_run_start(i_run_start),
    .i_bus(bus), .o_rdata(rdata), .o_halt_req(halt), .o_irq(irq));
  spb_fetch_src u_src (.i_mclk(i_mclk), .i_halt(halt), .o_fetch(fetch));
  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] msk, input logic [31:0] exp);
    @(posedge i_mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 32'h0};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    @(negedge i_mclk);
    check(rdata & msk, exp);
  endtask : rd
  // Reference: one fetch step, returns whether a break is due
  function automatic logic ref_step(input logic [23:0] x);
    logic h;
    h = 0;
    if (mode == 0) h = (x == a2) || (x == a3);
    else if ((r_seq == 2 || mode == 1) && x == a3) begin
      if (r_cnt == n) h = 1;
      else r_cnt++;
    end else if (mode == 3 && r_seq == 0 && x == a1) r_seq = 1;
    else if (((mode == 2 && r_seq == 0) || (mode == 3 && r_seq == 1)) && x == a2) begin
      r_seq = 2;
      armd = 1;
    end
    if (h) begin
      r_seq = 0;
      r_cnt = 0;
      brk = 1;
    end
    return h;
  endfunction : ref_step
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(77));
    repeat (6) @(posedge i_mclk);
    i_rst <= 0;
    rd(spb_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
    rd(spb_pkg::OFS_IRQ_EN, 32'hffffffff, 32'h0);
    rd(8'h40, 32'hffffffff, 32'h0);
    rd(spb_pkg::OFS_IRQ_CLR, 32'hffffffff, 32'h0);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      a1 = 24'($urandom);
      a2 = a1 ^ 24'h000010;
      a3 = a1 ^ 24'h400000;
      n = 24'($urandom % 4);
      wr(spb_pkg::OFS_ADDR3, {8'h0, a2});
      wr(spb_pkg::OFS_ADDR1, {8'h0, a1});
      wr(spb_pkg::OFS_ADDR2, {8'h0, a2});
      wr(spb_pkg::OFS_ADDR3, {8'h0, a3});
      wr(spb_pkg::OFS_COUNT, {8'h0, n});
      wr(spb_pkg::OFS_IRQ_CLR, 32'h3);
      wr(spb_pkg::OFS_IRQ_EN, 32'h0);
      // Channel one is disabled in mode 0 to prove it never hits
      wr(spb_pkg::OFS_CTRL, {27'h0, (m == 0) ? 3'b110 : 3'b111, mode});
      r_seq = 0;
      r_cnt = 0;
      brk = 0;
      armd = 0;
      for (int i = 0; i < int'(n) + 43; i++) begin
        int k;
        k = $urandom % 5;
        if (i < 2) a = (i == 0) ? a1 : a2;
        else if (i < int'(n) + 3) a = a3;
        else a = (k == 0) ? a1 : (k == 1) ? a2 : (k == 2) ? a3 : a3 ^ 24'h800000;
        if (i >= int'(n) + 3 && k == 4) begin
          u_src.stop();
          @(posedge i_mclk) i_run_start <= 1;
          @(posedge i_mclk) i_run_start <= 0;
          r_seq = 0;
          r_cnt = 0;
        end else begin
          u_src.fetch(a, hit);
          check({31'h0, hit}, {31'h0, ref_step(a)});
        end
      end
      u_src.stop();
      @(negedge i_mclk) check({31'h0, irq}, 32'h0);
      wr(spb_pkg::OFS_IRQ_EN, 32'h1);
      @(negedge i_mclk) check({31'h0, irq}, {31'h0, brk});
      if (m > 0) rd(spb_pkg::OFS_PROGRESS, (m > 1) ? 32'hffffff07 : 32'hffffff00,
        {r_cnt, 8'h0} | ((m > 1) ? 32'h1 << r_seq : 32'h0));
      rd(spb_pkg::OFS_IRQ_STAT, (m > 1) ? 32'h3 : 32'h1, {30'h0, armd & (m > 1), brk});
      wr(spb_pkg::OFS_IRQ_CLR, 32'h3);
      rd(spb_pkg::OFS_IRQ_STAT, 32'hffffffff, 32'h0);
    end
    print_verdict();
  end
endmodule : testbench
